// [rtl/ppec_pkg.sv]
package ppec_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [31:0] OFS_CTRL   = 32'h0000_0000;
    localparam logic [31:0] OFS_CMD    = 32'h0000_0004;
    localparam logic [31:0] OFS_ADDRLO = 32'h0000_0008;
    localparam logic [31:0] OFS_ADDRHI = 32'h0000_000C;
    localparam logic [31:0] OFS_WDATA  = 32'h0000_0010;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0014;
    localparam logic [31:0] OFS_FUSE   = 32'h0000_0018;
    localparam logic [31:0] OFS_LOCK   = 32'h0000_001C;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_OP_BIT      = 0;
    localparam int CTRL_ERASE_BIT   = 1;
    localparam int STAT_MODE_BIT    = 0;
    localparam int STAT_BUSY_BIT    = 1;
    localparam int STAT_LOCKED_BIT  = 2;
    localparam int STAT_RBYTE_LSB   = 8;
    localparam int FUSE_CKSEL_LSB   = 0;
    localparam int FUSE_RSTDIS_BIT  = 4;
    localparam int FUSE_PRESERVE_BIT = 5;

    // ****************************************************************
    // Reset values and codes
    // ****************************************************************
    localparam logic [7:0] FUSE_RST       = 8'h31;
    localparam logic [7:0] LOCK_ERASED    = 8'hFF;
    localparam logic [3:0] ENTRY_CODE     = 4'h0;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // ****************************************************************
    // Erase sweep lengths
    // ****************************************************************
    localparam int FLASH_WORDS  = 4096;
    localparam int EEPROM_BYTES = 512;

    typedef enum logic [1:0] {
        ERASE_IDLE,
        ERASE_FLASH,
        ERASE_EEPROM,
        ERASE_LOCKS
    } ppec_erase_e;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic        w_held;
        logic [31:0] awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [7:0]  cmd;
        logic [7:0]  addr_lo;
        logic [7:0]  addr_hi;
        logic [7:0]  wbyte;
        logic [7:0]  rbyte;
        logic [7:0]  fuse;
        logic [7:0]  lock;
        logic        prog_mode;
        logic        op_strobe;
        logic        erase_busy;
        logic        fstart;
        logic        estart;
        logic        abort;
        ppec_erase_e est;
    } ppec_top_s;

endpackage

// [rtl/ppec_sweep_if.sv]
`timescale 1ns/10ps
interface ppec_sweep_if;
    logic        start;
    logic        abort;
    logic        busy;
    logic        done;
    logic        strobe;
    logic [11:0] addr;

    modport sweeper (input start, input abort, output busy, output done, output strobe,
                     output addr);
    modport ctrl    (output start, output abort, input busy, input done, input strobe,
                     input addr);
endinterface

// [rtl/ppec_sweep.sv]
`timescale 1ns/10ps
module ppec_sweep #(
    parameter int COUNT = 16
) (
    input wire logic     aclk,
    input wire logic     aresetn,
    ppec_sweep_if.sweeper sw
);

    typedef struct packed {
        logic        busy;
        logic        done;
        logic        strobe;
        logic [11:0] addr;
    } ppec_sweep_s;

    ppec_sweep_s s;
    ppec_sweep_s next_s;

    // Steps one erase strobe per cycle over addresses 0 to COUNT-1.
    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        if (sw.abort) begin
            next_s.busy   = 1'b0;
            next_s.strobe = 1'b0;
        end else if (sw.start && !s.busy) begin
            next_s.busy   = 1'b1;
            next_s.strobe = 1'b1;
            next_s.addr   = 12'h000;
        end else if (s.busy) begin
            if (s.addr == 12'(COUNT - 1)) begin
                next_s.busy   = 1'b0;
                next_s.strobe = 1'b0;
                next_s.done   = 1'b1;
            end else begin
                next_s.addr = s.addr + 12'h001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sw.busy   = s.busy;
    assign sw.done   = s.done;
    assign sw.strobe = s.strobe;
    assign sw.addr   = s.addr;

endmodule

// [rtl/ppec_ctrl.sv]
`timescale 1ns/10ps
module ppec_ctrl (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        vcc_ok,
    input  wire logic        reset_pin_n,
    input  wire logic        hv_on_reset,
    input  wire logic [3:0]  prog_enable,
    input  wire logic [7:0]  mem_rdata,
    output logic             prog_mode,
    output logic             op_strobe,
    output logic [7:0]       mem_cmd,
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    output logic             flash_erase_strobe,
    output logic [11:0]      flash_erase_addr,
    output logic             eeprom_erase_strobe,
    output logic [11:0]      eeprom_erase_addr,
    output logic             erase_busy,
    output logic [3:0]       clock_source_select,
    output logic             reset_pin_disable_fuse,
    output logic             eeprom_preserve_fuse,
    output logic [7:0]       lock_bits
);

    ppec_pkg::ppec_top_s s;
    ppec_pkg::ppec_top_s next_s;

    ppec_sweep_if flash_if ();
    ppec_sweep_if eeprom_if ();

    // ****************************************************************
    // Erase sweepers
    // ****************************************************************
    ppec_sweep #(.COUNT(ppec_pkg::FLASH_WORDS)) u_flash (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sw      (flash_if.sweeper)
    );

    ppec_sweep #(.COUNT(ppec_pkg::EEPROM_BYTES)) u_eeprom (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sw      (eeprom_if.sweeper)
    );

    assign flash_if.start  = s.fstart;
    assign flash_if.abort  = s.abort;
    assign eeprom_if.start = s.estart;
    assign eeprom_if.abort = s.abort;

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic       exit_cond;
    logic       entry_cond;
    logic       wr_fire;
    logic       wr_ok;
    logic       locked;
    logic [7:0] wb;

    always_comb begin
        next_s     = s;
        exit_cond  = !vcc_ok || !reset_pin_n;
        entry_cond = vcc_ok && reset_pin_n && hv_on_reset && (prog_enable == ppec_pkg::ENTRY_CODE);
        locked     = (s.lock != ppec_pkg::LOCK_ERASED);
        wr_fire    = s.aw_held && s.w_held && !s.bvalid;
        wr_ok      = s.prog_mode && !s.erase_busy && s.wstrb[0];
        wb         = s.wdata[7:0];
        next_s.op_strobe = 1'b0;
        next_s.fstart    = 1'b0;
        next_s.estart    = 1'b0;
        next_s.abort     = 1'b0;

        // Programming mode entry and exit.
        if (exit_cond) begin
            next_s.prog_mode = 1'b0;
            next_s.abort     = 1'b1;
            next_s.est       = ppec_pkg::ERASE_IDLE;
        end else if (entry_cond) begin
            next_s.prog_mode = 1'b1;
        end

        // Write channel capture.
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata  = s_axi_wdata;
            next_s.wstrb  = s_axi_wstrb;
        end

        // Register write; command and address bytes persist until rewritten.
        if (wr_fire) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = ppec_pkg::RESP_OKAY;
            unique case (s.awaddr)
                ppec_pkg::OFS_CTRL: begin
                    if (wr_ok && wb[ppec_pkg::CTRL_OP_BIT]) begin
                        next_s.op_strobe = 1'b1;
                    end
                    if (wr_ok && wb[ppec_pkg::CTRL_ERASE_BIT] && !exit_cond) begin
                        next_s.erase_busy = 1'b1;
                        next_s.fstart     = 1'b1;
                        next_s.est        = ppec_pkg::ERASE_FLASH;
                    end
                end
                ppec_pkg::OFS_CMD:    if (wr_ok) next_s.cmd     = wb;
                ppec_pkg::OFS_ADDRLO: if (wr_ok) next_s.addr_lo = wb;
                ppec_pkg::OFS_ADDRHI: if (wr_ok) next_s.addr_hi = wb;
                ppec_pkg::OFS_WDATA:  if (wr_ok) next_s.wbyte   = wb;
                ppec_pkg::OFS_FUSE:   if (wr_ok && !locked) next_s.fuse = wb;
                ppec_pkg::OFS_LOCK:   if (wr_ok) next_s.lock = s.lock & wb;
                ppec_pkg::OFS_STATUS: begin
                end
                default: next_s.bresp = ppec_pkg::RESP_SLVERR;
            endcase
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Read byte captured on the clock edge that ends an operation strobe.
        if (s.op_strobe) begin
            next_s.rbyte = mem_rdata;
        end

        // Chip erase sequence; fuse byte is never touched here.
        if (!exit_cond) begin
            unique case (s.est)
                ppec_pkg::ERASE_IDLE: begin
                end
                ppec_pkg::ERASE_FLASH: begin
                    if (flash_if.done) begin
                        if (!s.fuse[ppec_pkg::FUSE_PRESERVE_BIT]) begin
                            next_s.est = ppec_pkg::ERASE_LOCKS;
                        end else begin
                            next_s.estart = 1'b1;
                            next_s.est    = ppec_pkg::ERASE_EEPROM;
                        end
                    end
                end
                ppec_pkg::ERASE_EEPROM: begin
                    if (eeprom_if.done) begin
                        next_s.est = ppec_pkg::ERASE_LOCKS;
                    end
                end
                ppec_pkg::ERASE_LOCKS: begin
                    next_s.lock       = ppec_pkg::LOCK_ERASED;
                    next_s.erase_busy = 1'b0;
                    next_s.est        = ppec_pkg::ERASE_IDLE;
                end
            endcase
        end else begin
            next_s.erase_busy = 1'b0;
        end

        // Read channel.
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = ppec_pkg::RESP_OKAY;
            next_s.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr)
                ppec_pkg::OFS_CTRL:   next_s.rdata[7:0] = 8'h00;
                ppec_pkg::OFS_CMD:    next_s.rdata[7:0] = s.cmd;
                ppec_pkg::OFS_ADDRLO: next_s.rdata[7:0] = s.addr_lo;
                ppec_pkg::OFS_ADDRHI: next_s.rdata[7:0] = s.addr_hi;
                ppec_pkg::OFS_WDATA:  next_s.rdata[7:0] = s.wbyte;
                ppec_pkg::OFS_FUSE:   next_s.rdata[7:0] = s.fuse;
                ppec_pkg::OFS_LOCK:   next_s.rdata[7:0] = s.lock;
                ppec_pkg::OFS_STATUS: begin
                    next_s.rdata[ppec_pkg::STAT_MODE_BIT]   = s.prog_mode;
                    next_s.rdata[ppec_pkg::STAT_BUSY_BIT]   = s.erase_busy;
                    next_s.rdata[ppec_pkg::STAT_LOCKED_BIT] = locked;
                    next_s.rdata[ppec_pkg::STAT_RBYTE_LSB +: 8] = s.rbyte;
                end
                default: next_s.rresp = ppec_pkg::RESP_SLVERR;
            endcase
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        next_s.awready = !next_s.aw_held;
        next_s.wready  = !next_s.w_held;
        next_s.arready = !next_s.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s      <= '0;
            s.fuse <= ppec_pkg::FUSE_RST;
            s.lock <= ppec_pkg::LOCK_ERASED;
            s.est  <= ppec_pkg::ERASE_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready          = s.awready;
    assign s_axi_wready           = s.wready;
    assign s_axi_bresp            = s.bresp;
    assign s_axi_bvalid           = s.bvalid;
    assign s_axi_arready          = s.arready;
    assign s_axi_rdata            = s.rdata;
    assign s_axi_rresp            = s.rresp;
    assign s_axi_rvalid           = s.rvalid;
    assign prog_mode              = s.prog_mode;
    assign op_strobe              = s.op_strobe;
    assign mem_cmd                = s.cmd;
    assign mem_addr               = {s.addr_hi, s.addr_lo};
    assign mem_wdata              = s.wbyte;
    assign flash_erase_strobe     = flash_if.strobe;
    assign flash_erase_addr       = flash_if.addr;
    assign eeprom_erase_strobe    = eeprom_if.strobe;
    assign eeprom_erase_addr      = eeprom_if.addr;
    assign erase_busy             = s.erase_busy;
    assign clock_source_select    = s.fuse[ppec_pkg::FUSE_CKSEL_LSB +: 4];
    assign reset_pin_disable_fuse = s.fuse[ppec_pkg::FUSE_RSTDIS_BIT];
    assign eeprom_preserve_fuse   = s.fuse[ppec_pkg::FUSE_PRESERVE_BIT];
    assign lock_bits              = s.lock;

endmodule

// [tb/ppec_prog_model.sv]
`timescale 1ns/10ps
module ppec_prog_model (
    input  wire logic        aclk,
    input  wire logic        mode_req,
    input  wire logic        power_req,
    input  wire logic        op_strobe,
    input  wire logic [15:0] mem_addr,
    output logic             vcc_ok,
    output logic             reset_pin_n,
    output logic             hv_on_reset,
    output logic [3:0]       prog_enable,
    output logic [7:0]       mem_rdata
);
    // ****
    // Programmer pin sequencing and a memory array that answers one op at a time.
    // ****
    logic [1:0] phase;
    logic [7:0] noise;

    initial begin
        {vcc_ok, reset_pin_n, hv_on_reset} = 3'h0;
        prog_enable = 4'hF;
        phase = 2'h0;
        noise = 8'h5A;
    end

    // Outside an operation the array output toggles so a stale byte is never read.
    assign mem_rdata = op_strobe ? (mem_addr[7:0] ^ 8'hA5) : noise;

    always @(posedge aclk) begin
        noise <= ~noise;
        if (!power_req) begin
            vcc_ok <= 1'h0;
            phase  <= 2'h0;
        end else if (!mode_req) begin
            reset_pin_n <= 1'h0;
            hv_on_reset <= 1'h0;
            prog_enable <= 4'hF;
            phase       <= 2'h0;
        end else if (phase == 2'h0) begin
            {vcc_ok, reset_pin_n, hv_on_reset} <= 3'h0;
            prog_enable <= 4'h0;
            phase       <= 2'h1;
        end else if (phase == 2'h1) begin
            {vcc_ok, reset_pin_n, hv_on_reset} <= 3'h7;
            phase <= 2'h2;
        end
    end
endmodule

// [tb/ppec_ctrl_chk.sv]
`timescale 1ns/10ps
module ppec_ctrl_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        vcc_ok,
    input wire logic        reset_pin_n,
    input wire logic        prog_mode,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  mem_cmd,
    input wire logic [15:0] mem_addr,
    input wire logic        flash_erase_strobe,
    input wire logic [11:0] flash_erase_addr,
    input wire logic        eeprom_erase_strobe,
    input wire logic        erase_busy,
    input wire logic [3:0]  clock_source_select,
    input wire logic        reset_pin_disable_fuse,
    input wire logic        eeprom_preserve_fuse,
    input wire logic [7:0]  lock_bits
);
    // ****
    // Flash strobes seen within the current erase.
    // ****
    logic [12:0] fseen;
    always_ff @(posedge aclk) begin
        if (!aresetn || !erase_busy) begin
            fseen <= 13'h0;
        end else if (flash_erase_strobe) begin
            fseen <= fseen + 13'h1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_exit_pin_low:
        assert property (!reset_pin_n |=> !prog_mode) else $error("mode kept, pin low");
    a_exit_power_off:
        assert property (!vcc_ok |=> !prog_mode) else $error("mode kept, no power");
    a_cmd_held:
        assert property ($changed(mem_cmd) |-> $rose(s_axi_bvalid)) else $error("cmd moved");
    a_addr_held:
        assert property ($changed(mem_addr) |-> $rose(s_axi_bvalid)) else $error("addr moved");
    a_fuse_kept:
        assert property (erase_busy |=> $stable({eeprom_preserve_fuse, reset_pin_disable_fuse,
            clock_source_select})) else $error("fuse moved in erase");
    a_lock_late:
        assert property ($changed(lock_bits) && $past(erase_busy) |->
            fseen == 13'(ppec_pkg::FLASH_WORDS)) else $error("lock cleared early");
    a_erase_unlock:
        assert property ($fell(erase_busy) && prog_mode |-> lock_bits == 8'hFF)
            else $error("lock not cleared");
    a_eeprom_kept:
        assert property (eeprom_erase_strobe |-> eeprom_preserve_fuse) else $error("eeprom hit");
    a_flash_step:
        assert property (flash_erase_strobe && $past(flash_erase_strobe) |->
            flash_erase_addr == $past(flash_erase_addr) + 12'h001) else $error("flash step");
    a_flash_start:
        assert property ($rose(erase_busy) |-> ##1 flash_erase_strobe &&
            flash_erase_addr == 12'h000) else $error("flash start");

    cover property ($fell(erase_busy) && eeprom_preserve_fuse);
    cover property ($fell(erase_busy) && !eeprom_preserve_fuse);
    cover property ($fell(prog_mode) && vcc_ok);
endmodule
bind ppec_ctrl ppec_ctrl_chk u_chk (.*);

// [tb/testbench.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("MISMATCH %0t got %h exp %h", $time, g, e); \
    end \
end
module testbench;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, vcc_ok, reset_pin_n, hv_on_reset, prog_mode, op_strobe;
    logic        flash_erase_strobe, eeprom_erase_strobe, erase_busy, reset_pin_disable_fuse;
    logic        eeprom_preserve_fuse, mode_req, power_req;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [3:0]  s_axi_wstrb, prog_enable, clock_source_select;
    logic [7:0]  mem_rdata, mem_cmd, mem_wdata, lock_bits;
    logic [11:0] flash_erase_addr, eeprom_erase_addr, elast;
    logic [5:0]  fz;
    logic [15:0] mem_addr;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    int          miscompares, checks_done, fcnt, ecnt, ocnt, f0, e0, k;

    ppec_ctrl uut (.*);
    ppec_prog_model partner (.*);

    always #20 aclk = ~aclk;
    assign fz = {eeprom_preserve_fuse, reset_pin_disable_fuse, clock_source_select};
    always @(posedge aclk) begin
        if (flash_erase_strobe) fcnt++;
        if (eeprom_erase_strobe) begin
            ecnt++;
            elast = eeprom_erase_addr;
        end
        if (op_strobe) ocnt++;
    end

    // ****
    // Bus tasks, a mode and erase wait task, and the closing report.
    // ****
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 100);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (n >= 100) begin miscompares++; summarize(); end
        @(posedge aclk);
    endtask

    task automatic rdr(input logic [31:0] a);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 100);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n >= 100) begin miscompares++; summarize(); end
        @(posedge aclk);
    endtask

    task automatic wm(input logic v, input int lim);
        int n;
        for (n = 0; n < lim && (prog_mode !== v || erase_busy !== 1'h0); n++) @(posedge aclk);
        if (n >= lim) begin miscompares++; summarize(); end
    endtask

    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, mode_req} = 3'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'hF;
        power_req = 1'h1;
        {miscompares, checks_done, fcnt, ecnt, ocnt} = 160'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rdr(ppec_pkg::OFS_FUSE);
        `CHK(rd, {24'h00_0000, ppec_pkg::FUSE_RST})
        rdr(ppec_pkg::OFS_LOCK);
        `CHK(rd, 32'h0000_00FF)
        rdr(32'h0000_0020);
        `CHK(resp, ppec_pkg::RESP_SLVERR)
        wr(32'h0000_0024, 32'h0000_0001);
        `CHK(resp, ppec_pkg::RESP_SLVERR)
        wr(ppec_pkg::OFS_CMD, 32'h0000_005A);
        `CHK(mem_cmd, 8'h00)
        mode_req <= 1'h1;
        wm(1'h1, 20);
        wr(ppec_pkg::OFS_CMD, 32'h0000_003C);
        wr(ppec_pkg::OFS_ADDRHI, 32'h0000_0012);
        for (k = 0; k < 2; k++) begin
            wr(ppec_pkg::OFS_ADDRLO, 32'h0000_0034 + 32'(k));
            wr(ppec_pkg::OFS_CTRL, 32'h0000_0001);
            rdr(ppec_pkg::OFS_STATUS);
            `CHK(mem_cmd, 8'h3C)
            `CHK(mem_addr, 16'h1234 + 16'(k))
            `CHK(rd[15:8], 8'h34 + 8'(k) ^ 8'hA5)
            `CHK(ocnt, k + 1)
        end
        wr(ppec_pkg::OFS_LOCK, 32'h0000_00FC);
        rdr(ppec_pkg::OFS_STATUS);
        `CHK(rd[2:0], 3'h5)
        wr(ppec_pkg::OFS_FUSE, 32'h0000_0010);
        `CHK(clock_source_select, 4'h1)
        for (k = 0; k < 2; k++) begin
            f0 = fcnt;
            e0 = ecnt;
            wr(ppec_pkg::OFS_CTRL, 32'h0000_0002);
            rdr(ppec_pkg::OFS_STATUS);
            `CHK(rd[1], 1'h1)
            wm(1'h1, 6000);
            `CHK(fcnt - f0, ppec_pkg::FLASH_WORDS)
            `CHK(ecnt - e0, k ? 0 : ppec_pkg::EEPROM_BYTES)
            `CHK(lock_bits, 8'hFF)
            `CHK(fz, k ? 6'h10 : 6'h31)
            `CHK(elast, 12'(ppec_pkg::EEPROM_BYTES - 1))
            wr(ppec_pkg::OFS_WDATA, 32'h0000_00A5 + 32'(k));
            `CHK(mem_wdata, 8'hA5 + 8'(k))
            wr(ppec_pkg::OFS_FUSE, 32'h0000_0010);
        end
        `CHK(fz[4:0], 5'h10)
        for (k = 0; k < 2; k++) begin
            if (k == 0) mode_req <= 1'h0;
            else power_req <= 1'h0;
            wm(1'h0, 20);
            wr(ppec_pkg::OFS_CMD, 32'h0000_0099);
            `CHK(mem_cmd, 8'h3C)
            mode_req  <= 1'h1;
            power_req <= 1'h1;
            wm(1'h1, 20);
            rdr(ppec_pkg::OFS_STATUS);
            `CHK(rd[0], 1'h1)
        end
        summarize();
    end
endmodule
